/* File: design/ldm_access.sv */
// locked data memory access: object requests in, one answer per request
// assumes requests arrive on core_clk_in from same-domain logic
//
// How it works
// RULE_01: index 3590/00 reads back the memory count, writes refused.
// RULE_02: permitted write to 3591/01..0E stores the value unchanged.
// RULE_03: master must write the unlock object UNLOCK_KEY before each write.
// RULE_04: every successful memory write re-arms the lock.
// RULE_05: read of 3591/xx returns that memory's current value.
// RULE_06: lock clears only when the unlock value equals 6B636C75.
// RULE_07: any other unlock value answers error, lock stays set. The code leaves the lock as it was, so an open lock stays open.
// RULE_08: fourteen independent 32-bit unsigned memories.
// RULE_09: memory write while locked is refused, memory unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"
module ldm_access
  import ldm_pkg::*;
(
  input  wire logic     core_clk_in, // 10 MHz core clock
  input  wire logic     resetn_in,   // async active-low reset
  input  wire ldm_req_t req_in,      // object request
  output var ldm_rsp_t  rsp_out,     // answer one cycle later
  output logic          locked_out   // write lock state
);
  // answer and lock live in one registered struct
  ldm_state_t  state_reg;
  ldm_state_t  state_next;
  logic [31:0] mem_reg [0:13]; // RULE_08
  logic        hit_cnt;
  logic        hit_mem;
  logic        hit_key;
  logic [3:0]  slot;
  logic        mem_we;

  // shared decode; the checks below read the same hit lines
  ldm_decode u_decode (
    .index_in (req_in.index),
    .sub_in   (req_in.sub),
    .cnt_out  (hit_cnt),
    .mem_out  (hit_mem),
    .key_out  (hit_key),
    .slot_out (slot)
  );

  // a write lands only when the lock is open
  assign mem_we = req_in.valid && req_in.write && hit_mem && !state_reg.locked; // RULE_09

  // request handling, one answer per strobe
  always_comb begin
    state_next           = state_reg;
    state_next.rsp.valid = 1'b0;
    if (req_in.valid) begin
      state_next.rsp.valid = 1'b1;
      state_next.rsp.error = 1'b0;
      state_next.rsp.code  = `LDM_ERR_NONE;
      state_next.rsp.data  = 32'h00000000;
      if (hit_cnt) begin
        if (req_in.write) begin
          state_next.rsp.error = 1'b1;
          state_next.rsp.code  = `LDM_ERR_ACCESS;
        end else begin
          state_next.rsp.data = `LDM_MEM_COUNT; // RULE_01
        end
      end else if (hit_mem) begin
        if (!req_in.write) begin
          state_next.rsp.data = mem_reg[slot]; // RULE_05
        end else if (state_reg.locked) begin
          state_next.rsp.error = 1'b1; // RULE_09
          state_next.rsp.code  = `LDM_ERR_ACCESS;
        end else begin
          state_next.locked = 1'b1; // RULE_04
        end
      end else if (hit_key) begin
        if (!req_in.write) begin
          state_next.rsp.error = 1'b1; // write-only object
          state_next.rsp.code  = `LDM_ERR_ACCESS;
        end else if (req_in.data == `LDM_UNLOCK_KEY) begin
          state_next.locked = 1'b0; // RULE_06
        end else begin
          state_next.rsp.error = 1'b1; // RULE_07
          state_next.rsp.code  = `LDM_ERR_VALUE;
        end
      end else begin
        state_next.rsp.error = 1'b1;
        state_next.rsp.code  = `LDM_ERR_NOOBJ;
      end
    end
  end

  // control state; lock closed out of reset so nothing writes unasked
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg        <= '0;
      state_reg.locked <= `LDM_LOCK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // memory array has no reset: contents stand for sensor data
  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      mem_reg[slot] <= req_in.data; // RULE_02
    end
  end

  assign rsp_out    = state_reg.rsp;
  assign locked_out = state_reg.locked;

  // --- checks ---
  // request shapes, sampled at the taking edge
  sequence s_unlock;
    req_in.valid && req_in.write && hit_key && (req_in.data == `LDM_UNLOCK_KEY);
  endsequence
  sequence s_badkey;
    req_in.valid && req_in.write && hit_key && (req_in.data != `LDM_UNLOCK_KEY);
  endsequence
  sequence s_keyread;
    req_in.valid && !req_in.write && hit_key;
  endsequence
  sequence s_memwrite;
    req_in.valid && req_in.write && hit_mem;
  endsequence
  sequence s_countwrite;
    req_in.valid && req_in.write && hit_cnt;
  endsequence
  sequence s_noobj;
    req_in.valid && !hit_cnt && !hit_mem && !hit_key;
  endsequence

  // answer shapes, seen one cycle after the taking edge
  sequence s_ok_answer;
    rsp_out.valid && !rsp_out.error && (rsp_out.code == `LDM_ERR_NONE);
  endsequence
  sequence s_access_refused;
    rsp_out.valid && rsp_out.error && (rsp_out.code == `LDM_ERR_ACCESS);
  endsequence

  // count object: constant on read, refused on write
  a_count_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_01
    req_in.valid && !req_in.write && hit_cnt |=> rsp_out.valid && !rsp_out.error
      && rsp_out.data == `LDM_MEM_COUNT)
    else $error("count object read wrong");
  a_count_write: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_01
    s_countwrite |=> s_access_refused)
    else $error("count object write not refused");

  // an open lock stores the word as given
  a_mem_store: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_02
    s_memwrite and !locked_out |=> mem_reg[$past(slot)] == $past(req_in.data))
    else $error("memory write not stored");

  // judged on the answer: the strobe cycle still shows the previous one
  a_unlock_first: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_03
    s_memwrite ##1 s_ok_answer |-> $past(!locked_out))
    else $error("write taken without unlock");

  // lock closes after a stored word, and only then
  a_relock_after: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_04
    s_memwrite and !locked_out |=> locked_out && rsp_out.valid && !rsp_out.error)
    else $error("lock not re-armed");
  a_lock_rise_cause: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_04
    $rose(locked_out) |-> $past(req_in.valid && req_in.write && hit_mem))
    else $error("lock closed without a memory write");
  a_read_keeps_lock: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.valid && !req_in.write |=> locked_out == $past(locked_out))
    else $error("read moved the lock");

  // unlock, store, read back on three straight cycles
  a_mem_readback: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_05
    s_unlock ##1 (s_memwrite and !locked_out) ##1 (req_in.valid && !req_in.write && hit_mem
      && slot == $past(slot)) |=> rsp_out.data == $past(req_in.data, 2))
    else $error("readback mismatch");

  // lock opens on the key, and nothing else opens it
  a_key_opens: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_06
    s_unlock |=> !locked_out && !rsp_out.error)
    else $error("key did not unlock");
  a_lock_drop_cause: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_06
    $fell(locked_out) |-> $past(req_in.valid && req_in.write && hit_key
      && (req_in.data == `LDM_UNLOCK_KEY)))
    else $error("lock opened without the key");
  a_key_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_keyread |=> s_access_refused)
    else $error("unlock object read not refused");

  // wrong key: value error, lock as before
  a_bad_key: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_07
    req_in.valid && req_in.write && hit_key && req_in.data != `LDM_UNLOCK_KEY
      |=> rsp_out.error && locked_out == $past(locked_out))
    else $error("bad key not refused");
  a_bad_key_code: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_07
    s_badkey |=> rsp_out.valid && (rsp_out.code == `LDM_ERR_VALUE))
    else $error("bad key gave wrong code");

  // decoder never points past the last memory
  a_slot_range: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_08
    hit_mem |-> (slot <= 4'hD))
    else $error("memory slot out of range");

  // closed lock: refused, and the addressed word left alone
  a_locked_write: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE_09
    s_memwrite and locked_out |=> s_access_refused
      and (mem_reg[$past(slot)] == $past(mem_reg[slot])))
    else $error("locked write not refused");

  // exactly one answer per strobe, no data on writes, unknown objects refused
  a_one_answer: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    rsp_out.valid |-> $past(req_in.valid))
    else $error("answer without request");
  a_answer_given: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.valid |=> rsp_out.valid)
    else $error("request left unanswered");
  a_idle_quiet: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !req_in.valid |=> !rsp_out.valid)
    else $error("answer while idle");
  a_write_data_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.valid && req_in.write |=> (rsp_out.data == 32'h00000000))
    else $error("write answer carries data");
  a_unknown_object: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_noobj |=> rsp_out.valid && rsp_out.error && (rsp_out.code == `LDM_ERR_NOOBJ))
    else $error("unknown object not refused");
endmodule : ldm_access
`default_nettype wire

/* File: design/ldm_defs.svh */
// constants for the locked data memory access block
// assumes inclusion by bare name from the modules and the bench
`ifndef LDM_DEFS_SVH
`define LDM_DEFS_SVH
`define LDM_IDX_COUNT   16'h3590
`define LDM_IDX_CONST   16'h3591
`define LDM_IDX_UNLOCK  16'h359F
`define LDM_SUB_ZERO    8'h00
`define LDM_SUB_FIRST   8'h01
`define LDM_SUB_LAST    8'h0E
`define LDM_MEM_COUNT   32'h0000000E
`define LDM_UNLOCK_KEY  32'h6B636C75
`define LDM_LOCK_RESET  1'b1
`define LDM_ERR_NONE    2'h0
`define LDM_ERR_ACCESS  2'h1
`define LDM_ERR_NOOBJ   2'h2
`define LDM_ERR_VALUE   2'h3
`endif

/* File: design/ldm_pkg.sv */
// types for the locked data memory access block
// assumes ldm_defs.svh on the include path
package ldm_pkg;
  typedef struct packed {
    logic        valid; // one-cycle request strobe
    logic        write; // 1 write, 0 read
    logic [15:0] index; // object index
    logic [7:0]  sub;   // object sub-index
    logic [31:0] data;  // write value
  } ldm_req_t;
  typedef struct packed {
    logic        valid; // one-cycle answer strobe
    logic        error; // request refused
    logic [1:0]  code;  // error cause
    logic [31:0] data;  // read value
  } ldm_rsp_t;
  typedef struct packed {
    logic     locked;
    ldm_rsp_t rsp;
  } ldm_state_t;
endpackage : ldm_pkg

/* File: design/ldm_decode.sv */
// object address decoder
// assumes pure combinational use from ldm_access
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"
module ldm_decode
  import ldm_pkg::*;
(
  input  wire logic [15:0] index_in, // object index
  input  wire logic [7:0]  sub_in,   // object sub-index
  output logic             cnt_out,  // count object hit
  output logic             mem_out,  // memory object hit
  output logic             key_out,  // unlock object hit
  output logic [3:0]       slot_out  // memory slot 0..13
);
  // sub-index range check shared by memory decode
  function automatic logic in_range(input logic [7:0] s);
    in_range = (s >= `LDM_SUB_FIRST) && (s <= `LDM_SUB_LAST);
  endfunction : in_range

  always_comb begin
    cnt_out  = (index_in == `LDM_IDX_COUNT) && (sub_in == `LDM_SUB_ZERO);
    mem_out  = (index_in == `LDM_IDX_CONST) && in_range(sub_in);
    key_out  = (index_in == `LDM_IDX_UNLOCK) && (sub_in == `LDM_SUB_FIRST);
    slot_out = 4'(sub_in - `LDM_SUB_FIRST); // only meaningful on mem_out
  end
endmodule : ldm_decode
`default_nettype wire

/* File: tb/ldm_master.sv */
// request source standing in for the fieldbus master
// assumes one answer one cycle after each taken strobe
`timescale 1ns/100ps
`default_nettype none
module ldm_master
  import ldm_pkg::*;
(
  input  wire logic     clk_in,  // core clock
  input  wire ldm_rsp_t rsp_in,  // answer from the block
  output var  ldm_req_t req_out  // request to the block
);
  initial req_out = '0;
  // one request, optional idle gap first; released fields are scrambled
  // so stale values are never mistaken for a held request
  task xfer(input int gap, input logic w, input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] d, output ldm_rsp_t r);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    req_out <= '{1'b1, w, idx, sub, d};
    @(posedge clk_in);
    req_out <= '{1'b0, ~w, ~idx, ~sub, ~d};
    #1 r = rsp_in;
  endtask : xfer
  // three requests on straight cycles, strobe held high throughout;
  // answer k is taken just after the edge that launches request k+1
  task chain(input ldm_req_t [2:0] q, output ldm_rsp_t [2:0] a);
    @(posedge clk_in);
    req_out <= q[0];
    for (int k = 1; k < 3; k++) begin
      @(posedge clk_in);
      req_out <= q[k];
      #1 a[k-1] = rsp_in;
    end
    @(posedge clk_in);
    req_out <= '{1'b0, ~q[2].write, ~q[2].index, ~q[2].sub, ~q[2].data};
    #1 a[2] = rsp_in;
  endtask : chain
endmodule : ldm_master
`default_nettype wire

/* File: tb/locked_data_memory_access_tb.sv */
// self-checking bench for the locked data memory access block
// assumes ldm_defs.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"
module locked_data_memory_access_tb
  import ldm_pkg::*;
;
  logic        core_clk;
  logic        resetn;
  ldm_req_t    req;
  ldm_rsp_t    rsp;
  logic        locked;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [31:0] exp_mem [14];
  logic [31:0] v;
  ldm_rsp_t    r;
  ldm_req_t [2:0] reqs;
  ldm_rsp_t [2:0] ans;
  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ldm_access u_dut (.core_clk_in(core_clk), .resetn_in(resetn), .req_in(req),
                    .rsp_out(rsp), .locked_out(locked));
  ldm_master u_mst (.clk_in(core_clk), .rsp_in(rsp), .req_out(req));
  // answer check: error flag follows from the expected code
  task chk_rsp(input logic [1:0] code, input logic [31:0] data);
    check_count++;
    if (r !== {1'b1, code != 2'h0, code, data}) begin
      n_errors++;
      $display("[ERR] %0t answer %h, want code %h data %h", $time, r, code, data);
    end
  endtask : chk_rsp
  task chk_lock(input logic exp);
    check_count++;
    if (locked !== exp) begin
      n_errors++;
      $display("[ERR] %0t lock state %b, want %b", $time, locked, exp);
    end
  endtask : chk_lock
  task go(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    u_mst.xfer(int'($urandom_range(2)), w, idx, sub, d, r);
  endtask : go
  task tally_and_finish;
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    void'($urandom(98));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk_lock(1'b1);
    go(1'b0, `LDM_IDX_COUNT, `LDM_SUB_ZERO, 32'h0);
    chk_rsp(`LDM_ERR_NONE, `LDM_MEM_COUNT);
    go(1'b1, `LDM_IDX_COUNT, `LDM_SUB_ZERO, $urandom);
    chk_rsp(`LDM_ERR_ACCESS, 32'h0);
    // per slot: bad key, good key, one write, refused second write
    for (int i = 0; i < 14; i++) begin
      v = $urandom;
      if (v == `LDM_UNLOCK_KEY) v = v ^ 32'h1;
      go(1'b1, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, v);
      chk_rsp(`LDM_ERR_VALUE, 32'h0);
      chk_lock(1'b1);
      go(1'b1, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, `LDM_UNLOCK_KEY);
      chk_rsp(`LDM_ERR_NONE, 32'h0);
      chk_lock(1'b0);
      exp_mem[i] = (i == 0) ? 32'hFFFFFFFF : $urandom;
      go(1'b1, `LDM_IDX_CONST, 8'(i + 1), exp_mem[i]);
      chk_rsp(`LDM_ERR_NONE, 32'h0);
      chk_lock(1'b1);
      go(1'b1, `LDM_IDX_CONST, 8'(i + 1), ~exp_mem[i]);
      chk_rsp(`LDM_ERR_ACCESS, 32'h0);
    end
    // read back in reverse so slot aliasing would show
    for (int i = 13; i >= 0; i--) begin
      go(1'b0, `LDM_IDX_CONST, 8'(i + 1), 32'h0);
      chk_rsp(`LDM_ERR_NONE, exp_mem[i]);
    end
    go(1'b0, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, 32'h0);
    chk_rsp(`LDM_ERR_ACCESS, 32'h0);
    go(1'b0, `LDM_IDX_CONST, 8'h0F, 32'h0);
    chk_rsp(`LDM_ERR_NOOBJ, 32'h0);
    go(1'b0, `LDM_IDX_COUNT, `LDM_SUB_FIRST, 32'h0);
    chk_rsp(`LDM_ERR_NOOBJ, 32'h0);
    // back-to-back: unlock, store, read back one slot
    v = $urandom;
    reqs[0] = '{1'b1, 1'b1, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, `LDM_UNLOCK_KEY};
    reqs[1] = '{1'b1, 1'b1, `LDM_IDX_CONST, 8'h05, v};
    reqs[2] = '{1'b1, 1'b0, `LDM_IDX_CONST, 8'h05, 32'h0};
    u_mst.chain(reqs, ans);
    r = ans[0];
    chk_rsp(`LDM_ERR_NONE, 32'h0);
    r = ans[1];
    chk_rsp(`LDM_ERR_NONE, 32'h0);
    r = ans[2];
    chk_rsp(`LDM_ERR_NONE, v);
    chk_lock(1'b1);
    // back-to-back: locked write, read back, wrong key
    reqs[0] = '{1'b1, 1'b1, `LDM_IDX_CONST, 8'h05, ~v};
    reqs[1] = '{1'b1, 1'b0, `LDM_IDX_CONST, 8'h05, 32'h0};
    reqs[2] = '{1'b1, 1'b1, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, ~`LDM_UNLOCK_KEY};
    u_mst.chain(reqs, ans);
    r = ans[0];
    chk_rsp(`LDM_ERR_ACCESS, 32'h0);
    r = ans[1];
    chk_rsp(`LDM_ERR_NONE, v);
    r = ans[2];
    chk_rsp(`LDM_ERR_VALUE, 32'h0);
    chk_lock(1'b1);
    // reset in mid-run with the lock open: lock closes, memories survive
    go(1'b1, `LDM_IDX_UNLOCK, `LDM_SUB_FIRST, `LDM_UNLOCK_KEY);
    chk_lock(1'b0);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk_lock(1'b1);
    go(1'b0, `LDM_IDX_CONST, 8'h05, 32'h0);
    chk_rsp(`LDM_ERR_NONE, v);
    tally_and_finish();
  end
endmodule : locked_data_memory_access_tb
`default_nettype wire
